// *** clg_codec_model.sv ***
// Purpose: Behavioural codec pair at the far end of the serial link
// Assumes: Bit clock period of 64 ns, made by the codec itself
// Notes:   Inputs held low for one frame after the clock starts

`timescale 1ns/100ps

module clg_codec_model (
    input  wire logic       codec_reset_n_in,
    input  wire logic       sync_in,
    input  wire logic       sleep_req_in,
    input  wire logic [1:0] level_in,
    input  wire logic [1:0] wake_in,
    output logic            bit_clk_out,
    output logic [1:0]      serial_out
);
    // ------------------------------------------------------------
    // Clock and power state
    // ------------------------------------------------------------
    logic       asleep_ff = 1'b0, armed_ff;
    logic [8:0] cnt_ff;

    // Sleep on request; wake at the end of a sync raised while asleep
    always @(posedge sync_in or posedge sleep_req_in) begin
        armed_ff <= asleep_ff;
    end
    always @(posedge sleep_req_in or negedge sync_in) begin
        asleep_ff <= sleep_req_in | (asleep_ff & ~armed_ff);
    end

    // Clock stands low asleep or in cold reset
    initial begin
        bit_clk_out = 1'b0;
        #7;
        forever begin
            #32;
            bit_clk_out = ~bit_clk_out & ~asleep_ff & codec_reset_n_in;
        end
    end

    // Start-up frame; data moves on falling edges
    always @(negedge bit_clk_out or negedge codec_reset_n_in
             or posedge asleep_ff) begin
        if (!codec_reset_n_in || asleep_ff) begin
            cnt_ff <= 9'h000;
        end else if (!cnt_ff[8]) begin
            cnt_ff <= cnt_ff + 9'h001;
        end
    end

    // Pull-downs: reset and idle read low
    // Ready follows the bench only, never drops on its own
    assign serial_out = !codec_reset_n_in ? 2'b00 :
                        asleep_ff ? wake_in :
                        cnt_ff[8] ? level_in : 2'b00;
endmodule : clg_codec_model

// *** clg_link_global.sv ***
// Purpose: Global control and status of the codec serial link
// Assumes: Link bit clock comes from the codec and may stop
// Notes:   Slot payload formatting lives elsewhere; data out is held low

`timescale 1ns/100ps

// What this block does
// - Secondary resume raises interrupt when bit 5 set
// - Primary resume raises interrupt when bit 4 set
// - Shut-off drives link outputs low, gates inputs
// - Writing warm bit issues link warm reset
// - Warm request ignored while bit clock runs
// - Warm bit self-clears after bit clock restarts
// - Cold bit drives codec reset pin, masked low by shut-off
// - Sleep states and reset force cold bit low
// - Input change sets bit 0, enable gates interrupt
// - Six and four channel bits read one
// - Power-down semaphores are suspend-well read/write bits
// - Read time-out bit sticks until software clears
// - Bits 14:12 show latest slot 12 bits 3:1
// - Secondary resume sets bit 11, write-one clears
// - Primary resume sets bit 10, write-one clears
// - Bits 9:8 mirror secondary and primary ready
// - Bit 7 follows pending mic input interrupt
// - Global registers take full 32-bit accesses only
// - Read waits four frames, then all-ones, time-out
// - Slot 12 bit 0 sets input change flag
module clg_link_global
    import clg_pkg::*;
(
    input  wire logic           core_clk_in,
    input  wire logic           reset_n_in,
    input  wire logic           suspend_reset_n_in,
    input  wire logic           sleep_in,
    input  wire clg_io_req_type io_req_in,
    output logic [31:0]         io_rdata_out,
    output logic                io_rvalid_out,
    input  wire logic           mic_irq_pending_in,
    input  wire logic           rd_req_in,
    input  wire logic           rd_reply_in,
    input  wire logic [15:0]    rd_reply_data_in,
    output logic                rd_done_out,
    output logic [15:0]         rd_data_out,
    output logic                irq_out,
    input  wire logic           bit_clk_in,
    input  wire logic [1:0]     codec_serial_in,
    output logic                sync_out,
    output logic                sdout_out,
    output logic                codec_reset_n_out
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [1:0]       shut_meta_ff, sdin_meta_ff, sdin_s2_ff, sdin_s3_ff;
    logic             shut_lk_ff, lk_sync_ff, bclk_tgl_ff, frm_tgl_ff;
    logic [7:0]       bit_cnt_ff;
    logic [2:0]       rx_sh_ff;
    clg_rx_type       rx_ff;
    logic [1:0]       sdin_gated, resume_evt, rdy_meta_ff, rdy_ff;
    logic [2:0]       bclk_sy_ff, frm_sy_ff;
    logic [5:0]       lost_cnt_ff;
    logic             bclk_run_ff, frame_evt;
    logic [3:0]       s12_ff;
    logic             cie_ff, cold_ff, shut_ff, prie_ff, srie_ff;
    logic             prs_ff, srs_ff, gpic_ff, rto_ff, rd_pend_ff;
    logic [1:0]       sem_ff;
    logic [2:0]       rd_frm_ff;
    logic             rd_timeout, warm_drive, wr_ctrl, wr_sta, rd_sta;
    logic             rd_done_ff, rvalid_ff;
    logic [15:0]      rd_data_ff;
    logic [31:0]      rdata_ff, ctrl_val, sta_val;
    logic [6:0]       wr_cnt_ff;
    clg_wr_state_type wr_state_ff;

    // Sticky flag: a set in the clearing cycle wins
    function automatic logic rwc_next(input logic cur, input logic set,
                                      input logic clr);
        rwc_next = set | (cur & ~clr);
    endfunction : rwc_next

    // ----------------------------------------------------------------
    // Link domain
    // ----------------------------------------------------------------
    // Shut-off crosses in as a level
    always_ff @(posedge bit_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            shut_meta_ff <= 2'h0;
            shut_lk_ff   <= 1'b0;
        end else begin
            shut_meta_ff <= {shut_meta_ff[0], shut_ff};
            shut_lk_ff   <= shut_meta_ff[1];
        end
    end

    // Input buffers off while the link is shut
    assign sdin_gated = codec_serial_in & {2{~shut_lk_ff}};

    // Frame counter, sync and bit clock activity toggle
    always_ff @(posedge bit_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bit_cnt_ff  <= 8'h00;
            lk_sync_ff  <= 1'b0;
            bclk_tgl_ff <= 1'b0;
        end else begin
            bit_cnt_ff  <= bit_cnt_ff + 8'h01;
            lk_sync_ff  <= (bit_cnt_ff < SYNC_BITS);
            bclk_tgl_ff <= ~bclk_tgl_ff;
        end
    end

    // Ready tags and slot 12 low bits, one toggle per frame
    always_ff @(posedge bit_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rx_sh_ff   <= 3'h0;
            rx_ff      <= '0;
            frm_tgl_ff <= 1'b0;
        end else begin
            rx_sh_ff <= {rx_sh_ff[1:0], sdin_gated[0]};
            if (bit_cnt_ff == RDY_CNT) begin
                rx_ff.pri_rdy <= sdin_gated[0];
                rx_ff.sec_rdy <= sdin_gated[1];
            end
            if (bit_cnt_ff == S12_CNT) begin
                rx_ff.slot12 <= {rx_sh_ff, sdin_gated[0]};
                frm_tgl_ff   <= ~frm_tgl_ff;
            end
        end
    end

    // ----------------------------------------------------------------
    // Crossings into the core domain
    // ----------------------------------------------------------------
    // Stage one feeds stage two only; edges come from later stages
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bclk_sy_ff   <= 3'h0;
            frm_sy_ff    <= 3'h0;
            rdy_meta_ff  <= 2'h0;
            rdy_ff       <= 2'h0;
            sdin_meta_ff <= 2'h0;
            sdin_s2_ff   <= 2'h0;
            sdin_s3_ff   <= 2'h0;
        end else begin
            bclk_sy_ff   <= {bclk_sy_ff[1:0], bclk_tgl_ff};
            frm_sy_ff    <= {frm_sy_ff[1:0], frm_tgl_ff};
            rdy_meta_ff  <= {rx_ff.sec_rdy, rx_ff.pri_rdy};
            rdy_ff       <= rdy_meta_ff;
            sdin_meta_ff <= codec_serial_in;
            sdin_s2_ff   <= sdin_meta_ff;
            sdin_s3_ff   <= sdin_s2_ff;
        end
    end

    assign frame_evt  = frm_sy_ff[2] ^ frm_sy_ff[1];
    // Resume is a rising serial input while the bit clock is absent
    assign resume_evt = sdin_s2_ff & ~sdin_s3_ff
                        & {2{~bclk_run_ff & ~shut_ff}};

    // Bit clock presence watchdog; the link clock may stop any time
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            lost_cnt_ff <= 6'h00;
            bclk_run_ff <= 1'b0;
        end else if (bclk_sy_ff[2] ^ bclk_sy_ff[1]) begin
            lost_cnt_ff <= 6'h00;
            bclk_run_ff <= 1'b1;
        end else if (lost_cnt_ff == BCLK_LOST_CYC) begin
            bclk_run_ff <= 1'b0;
        end else begin
            lost_cnt_ff <= lost_cnt_ff + 6'h01;
        end
    end

    // Slot 12 data changes on the same bit clock edge as its toggle
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s12_ff <= 4'h0;
        end else if (frame_evt) begin
            s12_ff <= rx_ff.slot12;
        end
    end

    // ----------------------------------------------------------------
    // Register access
    // ----------------------------------------------------------------
    // Only full dword accesses decode; others are ignored
    assign wr_ctrl = io_req_in.wr && io_req_in.be == BE_FULL
                     && io_req_in.addr == CTRL_OFS;
    assign wr_sta  = io_req_in.wr && io_req_in.be == BE_FULL
                     && io_req_in.addr == STA_OFS;
    assign rd_sta  = io_req_in.rd && io_req_in.be == BE_FULL
                     && io_req_in.addr == STA_OFS;

    // Plain control bits
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            {srie_ff, prie_ff, shut_ff} <= CTRL_RST[CB_SRIE:CB_SHUT];
            cie_ff <= CTRL_RST[CB_CIE];
        end else if (wr_ctrl) begin
            srie_ff <= io_req_in.wdata[CB_SRIE];
            prie_ff <= io_req_in.wdata[CB_PRIE];
            shut_ff <= io_req_in.wdata[CB_SHUT];
            cie_ff  <= io_req_in.wdata[CB_CIE];
        end
    end

    // Cold reset; sleep and bus reset hold the codec in reset
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cold_ff <= CTRL_RST[CB_COLD];
        end else if (sleep_in) begin
            cold_ff <= 1'b0;
        end else if (wr_ctrl) begin
            cold_ff <= io_req_in.wdata[CB_COLD];
        end
    end

    // Sticky event flags
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            prs_ff  <= STA_RST[SB_PRS];
            srs_ff  <= STA_RST[SB_SRS];
            gpic_ff <= STA_RST[SB_GPIC];
            rto_ff  <= STA_RST[SB_RTO];
        end else begin
            prs_ff  <= rwc_next(prs_ff, resume_evt[0],
                                wr_sta & io_req_in.wdata[SB_PRS]);
            srs_ff  <= rwc_next(srs_ff, resume_evt[1],
                                wr_sta & io_req_in.wdata[SB_SRS]);
            gpic_ff <= rwc_next(gpic_ff, frame_evt & rx_ff.slot12[0],
                                wr_sta & io_req_in.wdata[SB_GPIC]);
            // Read/write bit: writing zero clears it
            rto_ff  <= rwc_next(rto_ff, rd_timeout,
                                wr_sta & ~io_req_in.wdata[SB_RTO]);
        end
    end

    // Semaphores live in the suspend well, on their own reset
    always_ff @(posedge core_clk_in or negedge suspend_reset_n_in) begin
        if (!suspend_reset_n_in) begin
            sem_ff <= STA_RST[SB_MSP:SB_ASP];
        end else if (wr_sta) begin
            sem_ff <= io_req_in.wdata[SB_MSP:SB_ASP];
        end
    end

    // Read images; reserved positions stay zero
    always_comb begin
        ctrl_val          = '0;
        ctrl_val[CB_SRIE] = srie_ff;
        ctrl_val[CB_PRIE] = prie_ff;
        ctrl_val[CB_SHUT] = shut_ff;
        ctrl_val[CB_WARM] = (wr_state_ff != WR_IDLE);
        ctrl_val[CB_COLD] = codec_reset_n_out;
        ctrl_val[CB_CIE]  = cie_ff;
        sta_val           = STA_RST;
        sta_val[SB_MSP:SB_ASP]    = sem_ff;
        sta_val[SB_RTO]           = rto_ff;
        sta_val[SB_S12+2:SB_S12]  = s12_ff[3:1];
        sta_val[SB_SRS]           = srs_ff;
        sta_val[SB_PRS]           = prs_ff;
        sta_val[SB_SRD:SB_PRD]    = rdy_ff;
        sta_val[SB_MICI]          = mic_irq_pending_in;
        sta_val[SB_GPIC]          = gpic_ff;
    end

    // Answer one cycle after the request; unmapped reads return zero
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_ff  <= 32'h0000_0000;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= io_req_in.rd;
            if (rd_sta) begin
                rdata_ff <= sta_val;
            end else if (io_req_in.rd && io_req_in.be == BE_FULL
                         && io_req_in.addr == CTRL_OFS) begin
                rdata_ff <= ctrl_val;
            end else begin
                rdata_ff <= 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------------------------------
    // Warm reset sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_state_ff <= WR_IDLE;
            wr_cnt_ff   <= 7'h00;
        end else begin
            unique case (wr_state_ff)
                WR_IDLE: begin
                    wr_cnt_ff <= 7'h00;
                    // A running bit clock makes the request a no-op
                    if (wr_ctrl && io_req_in.wdata[CB_WARM]
                        && !bclk_run_ff) begin
                        wr_state_ff <= WR_DRIVE;
                    end
                end
                WR_DRIVE: begin
                    wr_cnt_ff <= wr_cnt_ff + 7'h01;
                    if (wr_cnt_ff == WARM_LAST) begin
                        wr_state_ff <= WR_WAIT;
                    end
                end
                WR_WAIT: begin
                    if (bclk_run_ff) begin
                        wr_state_ff <= WR_IDLE;
                    end
                end
                default: wr_state_ff <= WR_IDLE;
            endcase
        end
    end

    assign warm_drive = (wr_state_ff == WR_DRIVE);

    // ----------------------------------------------------------------
    // Codec read time-out
    // ----------------------------------------------------------------
    assign rd_timeout = rd_pend_ff && !rd_reply_in && frame_evt
                        && rd_frm_ff == RD_TO_LAST;

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_pend_ff <= 1'b0;
            rd_frm_ff  <= 3'h0;
            rd_done_ff <= 1'b0;
            rd_data_ff <= 16'h0000;
        end else begin
            rd_done_ff <= 1'b0;
            if (rd_req_in) begin
                rd_pend_ff <= 1'b1;
                rd_frm_ff  <= 3'h0;
            end else if (rd_pend_ff && rd_reply_in) begin
                rd_pend_ff <= 1'b0;
                rd_done_ff <= 1'b1;
                rd_data_ff <= rd_reply_data_in;
            end else if (rd_timeout) begin
                rd_pend_ff <= 1'b0;
                rd_done_ff <= 1'b1;
                rd_data_ff <= RD_ALL_ONES;
            end else if (rd_pend_ff && frame_evt) begin
                rd_frm_ff <= rd_frm_ff + 3'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Shut-off wins; a stalled frame drops sync, else it poses as warm reset
    assign sync_out = ~shut_ff & (lk_sync_ff & bclk_run_ff | warm_drive);
    assign sdout_out = 1'b0;
    assign codec_reset_n_out = cold_ff & ~shut_ff;
    assign irq_out = (prs_ff & prie_ff) | (srs_ff & srie_ff)
                     | (gpic_ff & cie_ff);
    assign io_rdata_out  = rdata_ff;
    assign io_rvalid_out = rvalid_ff;
    assign rd_done_out   = rd_done_ff;
    assign rd_data_out   = rd_data_ff;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_timeout;
        rd_pend_ff && frame_evt && !rd_reply_in && rd_frm_ff == 3'h3;
    endsequence

    sequence s_all_ones;
        rd_done_out && rd_data_out == 16'hffff && rto_ff;
    endsequence

    a_warm_ignored: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        wr_state_ff == WR_IDLE && wr_ctrl && bclk_run_ff
        |=> wr_state_ff == WR_IDLE)
        else $error("warm reset taken while bit clock ran");
    a_warm_width: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        $fell(warm_drive) |-> $past(wr_cnt_ff) == 7'h63)
        else $error("warm reset pulse has wrong width");
    a_warm_clear: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        wr_state_ff == WR_WAIT && bclk_run_ff |=> !ctrl_val[CB_WARM])
        else $error("warm bit did not clear");
    a_cold_sleep: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        sleep_in |=> !codec_reset_n_out)
        else $error("codec reset not forced in sleep");
    a_shut_pins: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        shut_ff |-> !sync_out && !codec_reset_n_out && !sdout_out)
        else $error("link output high during shut-off");
    a_prs_irq: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        resume_evt[0] && prie_ff && !wr_ctrl |=> prs_ff && irq_out)
        else $error("primary resume did not interrupt");
    a_srs_mask: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        srs_ff && !srie_ff && !prs_ff && !gpic_ff |-> !irq_out)
        else $error("masked secondary resume interrupted");
    a_prs_clear: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        wr_sta && io_req_in.wdata[SB_PRS] && !resume_evt[0]
        |=> !prs_ff)
        else $error("primary resume flag not cleared");
    a_read_timeout: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        s_timeout |=> s_all_ones)
        else $error("read time-out not reported");
    a_caps_fixed: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        rd_sta |=> io_rdata_out[21:20] == 2'b11 && io_rvalid_out)
        else $error("capability bits not one");

endmodule : clg_link_global

// *** clg_pkg.sv ***
// Purpose: Shared constants and types for the codec link global block
// Assumes: Core clock of 100 MHz, registers decoded by I/O offset
// Notes:   Offsets are relative to the I/O base address

package clg_pkg;

    // ----------------------------------------------------------------
    // Register offsets and access shape
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h3c;
    localparam logic [7:0] STA_OFS  = 8'h40;
    localparam logic [3:0] BE_FULL  = 4'hf;

    // Control bit positions
    localparam int CB_CIE  = 0;
    localparam int CB_COLD = 1;
    localparam int CB_WARM = 2;
    localparam int CB_SHUT = 3;
    localparam int CB_PRIE = 4;
    localparam int CB_SRIE = 5;

    // Status bit positions
    localparam int SB_GPIC = 0;
    localparam int SB_MICI = 7;
    localparam int SB_PRD  = 8;
    localparam int SB_SRD  = 9;
    localparam int SB_PRS  = 10;
    localparam int SB_SRS  = 11;
    localparam int SB_S12  = 12;
    localparam int SB_RTO  = 15;
    localparam int SB_ASP  = 16;
    localparam int SB_MSP  = 17;

    // Values after reset; status holds the hardwired capability bits
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] STA_RST  = 32'h0030_0000;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int          CLK_NS        = 10;
    localparam int          WARM_NS       = 1000;
    localparam logic [6:0]  WARM_CYC      =
        7'((WARM_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [6:0]  WARM_LAST     = WARM_CYC - 7'h01;
    localparam logic [5:0]  BCLK_LOST_CYC = 6'h20;
    localparam logic [2:0]  RD_TO_FRAMES  = 3'h4;
    localparam logic [2:0]  RD_TO_LAST    = RD_TO_FRAMES - 3'h1;
    localparam logic [15:0] RD_ALL_ONES   = 16'hffff;

    // Link frame positions, in bit clock counts
    localparam logic [7:0]  SYNC_BITS = 8'h10;
    localparam logic [7:0]  RDY_CNT   = 8'h01;
    localparam logic [7:0]  S12_CNT   = 8'h00;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  addr;
        logic        wr;
        logic        rd;
        logic [3:0]  be;
        logic [31:0] wdata;
    } clg_io_req_type;

    typedef struct packed {
        logic [3:0] slot12;
        logic       sec_rdy;
        logic       pri_rdy;
    } clg_rx_type;

    typedef enum logic [2:0] {
        WR_IDLE  = 3'b001,
        WR_DRIVE = 3'b010,
        WR_WAIT  = 3'b100
    } clg_wr_state_type;

endpackage : clg_pkg

// *** tb_top.sv ***
// Purpose: Self-checking bench for the link global block
// Assumes: Codec model supplies bit clock and serial inputs
// Notes:   Register rows first, link cases hand-written after

`timescale 1ns/100ps

module tb_top;
    import clg_pkg::*;
    typedef struct {
        logic [7:0]  a;
        logic [3:0]  be;
        logic        w;
        logic [31:0] d;
        logic [31:0] e;
    } clg_row_type;
    // ------------------------------------------------------------
    // Signals, clock and instances
    // ------------------------------------------------------------
    logic           clk = 1'b0, rst_n = 1'b0, slp = 1'b0, mic = 1'b0;
    logic           rq = 1'b0, rp = 1'b0, hold = 1'b0;
    logic [1:0]     lvl = 2'b00, wake = 2'b00, sdin;
    logic           bclk, rvalid, rd_done, irq, sync, sdo, crst_n;
    logic [15:0]    rdd;
    logic [31:0]    rdata, q;
    clg_io_req_type req = '0;
    int             n_fail = 0, total_checks = 0, i;
    clg_row_type    rows [6] = '{
        '{STA_OFS, 4'hf, 1'b0, 32'h0000_0000, STA_RST},
        '{CTRL_OFS, 4'hf, 1'b0, 32'h0000_0000, CTRL_RST},
        '{CTRL_OFS, 4'hf, 1'b1, 32'hffff_fff3, 32'h0000_0033},
        '{STA_OFS, 4'hf, 1'b1, 32'hffff_0000, 32'h0033_0000},
        '{CTRL_OFS, 4'h3, 1'b1, 32'h0000_0000, 32'h0000_0033},
        '{8'h44, 4'hf, 1'b1, 32'hffff_ffff, 32'h0000_0000}};

    // Core clock of 100 MHz
    always #5 clk = ~clk;

    clg_link_global dut (.core_clk_in(clk), .reset_n_in(rst_n),
        .suspend_reset_n_in(rst_n), .sleep_in(slp), .io_req_in(req),
        .io_rdata_out(rdata), .io_rvalid_out(rvalid),
        .mic_irq_pending_in(mic), .rd_req_in(rq), .rd_reply_in(rp),
        .rd_reply_data_in(16'h1234), .rd_done_out(rd_done),
        .rd_data_out(rdd), .irq_out(irq), .bit_clk_in(bclk),
        .codec_serial_in(sdin), .sync_out(sync), .sdout_out(sdo),
        .codec_reset_n_out(crst_n));
    clg_codec_model u_codec (.codec_reset_n_in(crst_n), .sync_in(sync),
        .sleep_req_in(hold), .level_in(lvl), .wake_in(wake),
        .bit_clk_out(bclk), .serial_out(sdin));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One-cycle strobe, held to the sampling edge
    task automatic io(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(negedge clk);
        req = '{a, w, !w, BE_FULL, d};
        @(negedge clk);
        req = '{a, 1'b0, 1'b0, BE_FULL, d};
        q = rdata;
        if (!w) chk("rvalid", 1, rvalid);
    endtask : io

    task automatic hang(input logic bad);
        if (bad) begin
            n_fail++;
            $display("[ERR] wait expected done seen timeout");
            print_verdict();
        end
    endtask : hang

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        foreach (rows[k]) begin
            if (rows[k].w) begin
                @(negedge clk);
                req = '{rows[k].a, 1'b1, 1'b0, rows[k].be, rows[k].d};
                @(negedge clk);
                req = '0;
            end
            io(1'b0, rows[k].a, '0);
            chk("row", rows[k].e, q);
        end
        $display("test registers done");
        lvl = 2'b11;
        repeat (4000) @(negedge clk);
        io(1'b0, STA_OFS, '0);
        chk("link status", 32'h0033_7301, q);
        chk("irq on", 1, irq);
        io(1'b1, CTRL_OFS, 32'h0000_0032);
        chk("irq gated", 0, irq);
        mic = 1'b1;
        io(1'b0, STA_OFS, '0);
        chk("mic set", 1, q[SB_MICI]);
        mic = 1'b0;
        io(1'b0, STA_OFS, '0);
        chk("mic clear", 0, q[SB_MICI]);
        $display("test link done");
        // Codec read timed out, then answered
        rq = 1'b1;
        @(negedge clk);
        rq = 1'b0;
        for (i = 0; i < 10000 && rd_done !== 1'b1; i++) @(negedge clk);
        hang(i == 10000);
        chk("timeout data", 32'h0000_ffff, rdd);
        io(1'b0, STA_OFS, '0);
        chk("timeout flag", 1, q[SB_RTO]);
        rq = 1'b1;
        @(negedge clk);
        rq = 1'b0;
        rp = 1'b1;
        @(negedge clk);
        rp = 1'b0;
        chk("reply", 32'h0001_1234, {rd_done, rdd});
        io(1'b0, STA_OFS, '0);
        chk("flag sticks", 1, q[SB_RTO]);
        io(1'b1, STA_OFS, '0);
        io(1'b0, STA_OFS, '0);
        chk("flag cleared", 0, q[SB_RTO]);
        $display("test codec read done");
        io(1'b1, CTRL_OFS, 32'h0000_000a);
        repeat (8) @(negedge clk);
        chk("shut pins", 0, {crst_n, sync, sdo});
        io(1'b1, CTRL_OFS, 32'h0000_0012);
        repeat (200) @(negedge clk);
        io(1'b1, CTRL_OFS, 32'h0000_0016);
        io(1'b0, CTRL_OFS, '0);
        chk("warm ignored", 32'h0000_0012, q);
        // Codec sleeps, both lines signal resume
        hold = 1'b1;
        @(negedge clk);
        hold = 1'b0;
        repeat (100) @(negedge clk);
        wake = 2'b11;
        repeat (10) @(negedge clk);
        wake = 2'b00;
        io(1'b0, STA_OFS, '0);
        chk("resume flags", 2'b11, q[SB_SRS:SB_PRS]);
        chk("resume irq", 1, irq);
        io(1'b1, STA_OFS, 32'h0000_0400);
        chk("sec irq off", 0, irq);
        io(1'b1, STA_OFS, 32'h0000_0800);
        io(1'b0, STA_OFS, '0);
        chk("flags cleared", 0, q[SB_SRS:SB_PRS]);
        io(1'b1, CTRL_OFS, 32'h0000_0016);
        io(1'b0, CTRL_OFS, '0);
        chk("warm bit", 1, q[CB_WARM]);
        repeat (40) @(negedge clk);
        chk("warm sync", 1, sync);
        for (i = 0; i < 100 && q[CB_WARM] !== 1'b0; i++) begin
            repeat (20) @(negedge clk);
            io(1'b0, CTRL_OFS, '0);
        end
        hang(i == 100);
        chk("warm done", 0, q[CB_WARM]);
        $display("test resume and warm done");
        slp = 1'b1;
        repeat (3) @(negedge clk);
        io(1'b0, CTRL_OFS, '0);
        chk("sleep cold", 0, {q[CB_COLD], crst_n});
        slp = 1'b0;
        repeat (100) @(negedge clk);
        io(1'b1, CTRL_OFS, 32'h0000_0002);
        io(1'b0, CTRL_OFS, '0);
        chk("cold release", 32'h0000_0002, q);
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        chk("reset pin", 0, crst_n);
        rst_n = 1'b1;
        io(1'b0, CTRL_OFS, '0);
        chk("reset ctrl", CTRL_RST, q);
        $display("test sleep and reset done");
        print_verdict();
    end
endmodule : tb_top
